// >>> pkg/dio_map_pkg.sv
// Behaviour
// - first three inputs accept changes after programmable delay
// - polarity zero: high level counts as active
// - polarity one: low level counts as active
// - function 50 clears running time when timing enabled
// - function 51 turns two-wire one into three-wire one
// - function 52 prohibits reverse like the setting
// - mux terminal: mode 0 pulse, mode 1 open collector
// - pulse output never exceeds 100 kHz
// - five output selectors, range 0 to 41, defaults
// - function 1 on while running, zero frequency included
// - function 2 on after fault stop
// - function 5 on running at zero, off stopped
// - function 7 on ten seconds before overload trip
// - functions 8 and 9 on at count values
// - function 10 on when length exceeds setting
// - function 11 gives one 250 ms pulse
// - function 12 on past accumulated run threshold
// - function 13 on when frequency held at limit
// - function 15 on when drive ready to run
// - function 16 on while first analog exceeds second
// - function 17 upper limit, 18 lower while running
// - function 19 on at undervoltage
package dio_map_pkg;
  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int DELAY_TICK_MS = 100; // delay setting unit, 0.1 s
  localparam int DELAY_TICK_CYCLES = CLK_HZ / 1000 * DELAY_TICK_MS;
  localparam int PLC_PULSE_MS = 250; // cycle-complete pulse width
  localparam int PLC_PULSE_CYCLES = CLK_HZ / 1000 * PLC_PULSE_MS;
  localparam int PULSE_MAX_KHZ = 100; // highest pulse frequency
  localparam int PULSE_MIN_PERIOD = (CLK_HZ + PULSE_MAX_KHZ * 1000 - 1) / (PULSE_MAX_KHZ * 1000);
  localparam logic [15:0] PULSE_MIN_HALF = 16'(PULSE_MIN_PERIOD / 2);
  localparam logic [15:0] DELAY_MAX = 16'h8CA0; // 3600.0 s in tenths
  // terminal counts and function codes
  localparam int NUM_DI = 5;
  localparam int NUM_DELAYED = 3;
  localparam int NUM_DO = 5;
  localparam int FUNC_MAX = 41;
  localparam logic [5:0] IN_FUNC_CLR_TIME = 6'h32; // 50
  localparam logic [5:0] IN_FUNC_WIRE_SW = 6'h33; // 51
  localparam logic [5:0] IN_FUNC_NO_REV = 6'h34; // 52
  // run command schemes
  localparam logic [1:0] SCHEME_TWO_WIRE1 = 2'h0;
  localparam logic [1:0] SCHEME_THREE_WIRE1 = 2'h2;
  // register indices
  localparam logic [5:0] REG_IN_DELAY0 = 6'h00; // 0x00..0x02
  localparam logic [5:0] REG_IN_POL = 6'h03;
  localparam logic [5:0] REG_IN_FUNC0 = 6'h04; // 0x04..0x08
  localparam logic [5:0] REG_CTRL = 6'h09;
  localparam logic [5:0] REG_OUT_FUNC0 = 6'h0A; // 0x0A..0x0E
  localparam logic [5:0] REG_PULSE_PER = 6'h0F;
  localparam logic [5:0] REG_STATUS = 6'h10;
  // control register fields
  localparam int CTRL_TIMING_BIT = 0;
  localparam int CTRL_NOREV_BIT = 1;
  localparam int CTRL_SCHEME_LSB = 2;
  localparam int CTRL_MUXMODE_BIT = 4;
  localparam int STATUS_OUT_LSB = 8;
  // reset values of the output selectors
  localparam logic [5:0] OUT_FUNC_RST [NUM_DO] = '{6'h00, 6'h02, 6'h00, 6'h01, 6'h04};
endpackage : dio_map_pkg

// >>> sim/drive_terminal_io_mapper_bench.sv
`timescale 1ns/100ps
// self-checking bench of the terminal mapper
module drive_terminal_io_mapper_bench;
  localparam int TICK = 10; // shortened delay tick
  localparam int PLC = 20; // shortened sequencer pulse
  localparam logic [5:0] DFLT [5] = '{6'h00, 6'h02, 6'h00, 6'h01, 6'h04};
  localparam logic [5:0] CODES [14] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07,
    6'h08, 6'h09, 6'h0A, 6'h0C, 6'h0D, 6'h0F, 6'h11, 6'h13};
  localparam int BITS [14] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 15};
  localparam logic [5:0] UNDEF [5] = '{6'h00, 6'h0E, 6'h14, 6'h29, 6'h3F};
  logic clk = 1'b0; // system clock
  logic nrst = 1'b0; // reset, active low
  logic [5:0] addr = 6'h00; // register index
  logic [15:0] wdata = 16'h0000; // write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic [15:0] rdata; // read data
  logic [4:0] sw = 5'h00; // field switches
  logic [4:0] pins; // terminal levels
  logic [15:0] st = 16'h0000; // status levels, see port map
  logic plc_done = 1'b0; // sequencer cycle pulse
  logic [11:0] ain1 = 12'h000; // first analog value
  logic [11:0] ain2 = 12'h000; // second analog value
  logic [4:0] term; // output terminals 0..4
  logic [1:0] scheme; // effective run scheme
  logic rp; // reverse prohibited
  logic rtc; // running time clear pulse
  logic [8:0] obs; // all observed outputs
  int edges; // pulse edges seen
  int min_run; // shortest pulse level
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0; // cycles run
  assign obs = {rtc, rp, scheme, term};
  // clock of 100 ns
  always #50 clk = ~clk;
  drive_terminal_io_mapper #(.TICK_CYCLES(TICK), .PLC_CYCLES(PLC)) dut_u (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .dig_in_one(pins[0]), .dig_in_two(pins[1]),
    .dig_in_three(pins[2]), .dig_in_four(pins[3]), .dig_in_five(pins[4]),
    .run_time_clear(rtc), .eff_run_scheme(scheme), .reverse_prohibit(rp),
    .running(st[0]), .fault_stop(st[1]), .freq_level_det(st[2]),
    .freq_reached(st[3]), .zero_freq(st[4]), .motor_ovl_pending(st[5]),
    .drive_ovl_pending(st[6]), .set_count_hit(st[7]), .desig_count_hit(st[8]),
    .length_over(st[9]), .plc_cycle_done(plc_done), .accum_run_over(st[10]),
    .freq_limited(st[11]), .drive_ready(st[12]), .analog_in_first(ain1),
    .analog_in_second(ain2), .freq_upper_hit(st[13]), .freq_lower_hit(st[14]),
    .undervoltage(st[15]), .multiplexed_output(term[0]), .main_relay_out(term[1]),
    .ext_relay_out(term[2]), .first_digital_output(term[3]),
    .second_digital_output(term[4]));
  field_wiring u_field (.clk(clk), .sw_closed(sw), .pulse_in(term[0]), .pins(pins),
    .edges(edges), .min_run(min_run));
  // verdict and end of run
  task conclude;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  // wait n edges, then let their updates land
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one-cycle register write
  task wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // one-cycle register read, data in the next cycle
  task rd_reg(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // status vector and switch drivers
  task put(input logic [15:0] v);
    @(posedge clk);
    st <= v;
  endtask : put
  task sw_set(input logic [4:0] v);
    @(posedge clk);
    sw <= v;
  endtask : sw_set
  // terminal j one cycle after the status change
  task ct(input int j, input logic v, input string m);
    tick(1);
    chk(16'(term[j]), 16'(v), m);
  endtask : ct
  // bounded wait for one observed output
  task wait_bit(input int idx, input logic v, input int lim, input string m);
    for (int i = 0; i < lim && obs[idx] !== v; i++) tick(1);
    chk(16'(obs[idx]), 16'(v), m);
  endtask : wait_bit
  // count clear pulses over a short window
  task cnt_rtc(output int n);
    n = 0;
    for (int i = 0; i < 12; i++) begin
      tick(1);
      if (rtc === 1'b1) n++;
    end
  endtask : cnt_rtc
  // reset values, unmapped place, quiet outputs
  task t_defaults;
    logic [15:0] d;
    chk(16'(obs), 16'h0000, "outputs after reset");
    for (int i = 0; i < 5; i++) begin
      rd_reg(6'h0A + 6'(i), d);
      chk(d, {10'h000, DFLT[i]}, "selector default");
    end
    wr_reg(6'h3F, 16'hFFFF);
    rd_reg(6'h3F, d);
    chk(d, 16'h0000, "unmapped read");
  endtask : t_defaults
  // every single-condition function on a rotating terminal
  task t_out_table;
    int j;
    for (int i = 0; i < 14; i++) begin
      j = 1 + i % 4;
      wr_reg(6'h0A + 6'(j), {10'h000, CODES[i]});
      put(16'h0000);
      ct(j, 1'b0, "function idle");
      put(16'h0001 << BITS[i]);
      ct(j, 1'b1, "function on");
    end
  endtask : t_out_table
  // combined conditions and undefined codes
  task t_composite;
    wr_reg(6'h0D, 16'h0005);
    put(16'h0010);
    ct(3, 1'b0, "zero speed while stopped");
    put(16'h0011);
    ct(3, 1'b1, "zero speed running");
    wr_reg(6'h0D, 16'h0012);
    put(16'h4000);
    ct(3, 1'b0, "lower limit stopped");
    put(16'h4001);
    ct(3, 1'b1, "lower limit running");
    wr_reg(6'h0D, 16'h0010);
    @(posedge clk);
    ain1 <= 12'h064;
    ain2 <= 12'h064;
    ct(3, 1'b0, "analog equal");
    @(posedge clk);
    ain1 <= 12'h065;
    ct(3, 1'b1, "analog first greater");
    put(16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      wr_reg(6'h0D, {10'h000, UNDEF[i]});
      ct(3, 1'b0, "undefined code off");
    end
    put(16'h0000);
  endtask : t_composite
  // sequencer pulse width
  task t_plc;
    int n;
    wr_reg(6'h0D, 16'h000B);
    @(posedge clk);
    plc_done <= 1'b1;
    @(posedge clk);
    plc_done <= 1'b0;
    #1;
    n = 0;
    for (int i = 0; i < PLC + 10; i++) begin
      if (term[3] === 1'b1) n++;
      tick(1);
    end
    chk(16'(n), 16'(PLC), "sequencer pulse width");
  endtask : t_plc
  // delayed input, dropped glitch, prohibit setting
  task t_delay;
    int n;
    wr_reg(6'h00, 16'h0003);
    wr_reg(6'h04, 16'h0034);
    sw_set(5'h01);
    tick(15);
    chk(16'(rp), 16'h0000, "change held back");
    wait_bit(7, 1'b1, 60, "change accepted");
    sw_set(5'h00);
    tick(8);
    sw_set(5'h01);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (rp !== 1'b1) n++;
    end
    chk(16'(n), 16'h0000, "short glitch dropped");
    sw_set(5'h00);
    wait_bit(7, 1'b0, 60, "release accepted");
    wr_reg(6'h04, 16'h0000);
    wr_reg(6'h09, 16'h0002);
    wait_bit(7, 1'b1, 4, "prohibit setting");
    wr_reg(6'h09, 16'h0000);
    wait_bit(7, 1'b0, 4, "prohibit setting off");
  endtask : t_delay
  // polarity on an undelayed input
  task t_pol;
    logic [15:0] d;
    wr_reg(6'h03, 16'h0008);
    wr_reg(6'h07, 16'h0034);
    wait_bit(7, 1'b1, 8, "open low-active input");
    rd_reg(6'h10, d);
    chk(d & 16'h001F, 16'h0008, "active input status");
    sw_set(5'h08);
    wait_bit(7, 1'b0, 8, "closed low-active input");
    wr_reg(6'h03, 16'h0000);
    wait_bit(7, 1'b1, 8, "closed high-active input");
    sw_set(5'h00);
    wait_bit(7, 1'b0, 8, "open high-active input");
    wr_reg(6'h07, 16'h0000);
  endtask : t_pol
  // wire scheme switch and running time clear
  task t_funcs;
    int n;
    wr_reg(6'h05, 16'h0033);
    sw_set(5'h02);
    wait_bit(6, 1'b1, 8, "three-wire while active");
    chk(16'(scheme), 16'h0002, "scheme three-wire one");
    sw_set(5'h00);
    wait_bit(6, 1'b0, 8, "two-wire again");
    wr_reg(6'h09, 16'h0004);
    sw_set(5'h02);
    tick(8);
    chk(16'(scheme), 16'h0001, "other scheme kept");
    sw_set(5'h00);
    wr_reg(6'h05, 16'h0000);
    wr_reg(6'h06, 16'h0032);
    wr_reg(6'h09, 16'h0001);
    sw_set(5'h04);
    cnt_rtc(n);
    chk(16'(n), 16'h0001, "one clear pulse");
    sw_set(5'h00);
    wr_reg(6'h09, 16'h0000);
    sw_set(5'h04);
    cnt_rtc(n);
    chk(16'(n), 16'h0000, "no clear without timing");
    sw_set(5'h00);
    wr_reg(6'h06, 16'h0000);
  endtask : t_funcs
  // pulse mode rate cap, then open collector mode
  task t_mux;
    int e0;
    wr_reg(6'h0F, 16'h000A);
    e0 = edges;
    tick(400);
    chk(16'(edges - e0 > 3), 16'h0001, "pulse train runs");
    chk(16'(min_run >= 50), 16'h0001, "pulse rate capped");
    wr_reg(6'h09, 16'h0010);
    wr_reg(6'h0A, 16'h0013);
    put(16'h8000);
    ct(0, 1'b1, "open collector on");
    put(16'h0000);
    ct(0, 1'b0, "open collector off");
  endtask : t_mux
  // cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: run too long", $time);
      conclude;
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
    t_defaults;
    t_out_table;
    t_composite;
    t_plc;
    t_delay;
    t_pol;
    t_funcs;
    t_mux;
    conclude;
  end
endmodule : drive_terminal_io_mapper_bench

// >>> sim/field_wiring.sv
`timescale 1ns/100ps
// field side: switches to common return and a pulse receiver
module field_wiring (
  input wire logic clk, // receiver sample clock
  input wire logic [4:0] sw_closed, // switch state per input terminal
  input wire logic pulse_in, // multiplexed terminal level
  output logic [4:0] pins, // terminal levels seen by the drive
  output int edges, // level changes seen on the pulse line
  output int min_run // shortest complete level run, cycles
);
  int run; // cycles since the last change
  logic last; // level at the previous sample
  // a closed switch pulls its terminal to the high level
  assign pins = sw_closed;
  // measure runs of the pulse train; the first run is partial
  initial begin
    edges = 0;
    min_run = 100000;
    run = 0;
    last = 1'b0;
  end
  always @(posedge clk) begin
    if (pulse_in !== last && pulse_in !== 1'bx) begin // unknown before reset is no change
      if (edges > 0 && run < min_run) begin
        min_run = run;
      end
      edges++;
      run = 1;
    end else begin
      run++;
    end
    last = pulse_in;
  end
endmodule : field_wiring

// >>> src/di_delay_filter.sv
`timescale 1ns/100ps
// one input terminal: synchroniser plus change-acceptance delay
module di_delay_filter (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin, // raw terminal level
  input wire logic tick, // one pulse per 0.1 s
  input wire logic [15:0] delay, // delay in tenths of a second
  output logic level // accepted level
);
  logic s1_q, s2_q, s3_q; // synchroniser chain
  logic stable_q; // level once second and third agree
  logic acc_q; // accepted level
  logic [15:0] cnt_q; // elapsed tenths since change
  logic expired;

  // the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      stable_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        stable_q <= s3_q;
      end
    end
  end

  assign expired = (cnt_q >= delay);

  // accept a pending change once the delay has run out
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (stable_q == acc_q) begin
      cnt_q <= 16'h0000; // change withdrawn, restart
    end else if (expired) begin
      acc_q <= stable_q;
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign level = acc_q;
endmodule : di_delay_filter

// >>> src/drive_terminal_io_mapper.sv
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// digital terminal mapper of the drive: inputs, outputs, register port
module drive_terminal_io_mapper #(
  parameter int TICK_CYCLES = dio_map_pkg::DELAY_TICK_CYCLES,
  parameter int PLC_CYCLES = dio_map_pkg::PLC_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // input terminals
  input wire logic dig_in_one,
  input wire logic dig_in_two,
  input wire logic dig_in_three,
  input wire logic dig_in_four,
  input wire logic dig_in_five,
  // input-function results toward the core
  output logic run_time_clear,
  output logic [1:0] eff_run_scheme,
  output logic reverse_prohibit,
  // drive status from the core, same clock
  input wire logic running,
  input wire logic fault_stop,
  input wire logic freq_level_det,
  input wire logic freq_reached,
  input wire logic zero_freq,
  input wire logic motor_ovl_pending,
  input wire logic drive_ovl_pending,
  input wire logic set_count_hit,
  input wire logic desig_count_hit,
  input wire logic length_over,
  input wire logic plc_cycle_done,
  input wire logic accum_run_over,
  input wire logic freq_limited,
  input wire logic drive_ready,
  input wire logic [11:0] analog_in_first,
  input wire logic [11:0] analog_in_second,
  input wire logic freq_upper_hit,
  input wire logic freq_lower_hit,
  input wire logic undervoltage,
  // output terminals
  output logic multiplexed_output,
  output logic main_relay_out,
  output logic ext_relay_out,
  output logic first_digital_output,
  output logic second_digital_output
);
  localparam logic [21:0] TICK_LAST = 22'(TICK_CYCLES - 1);
  localparam logic [21:0] PLC_LOAD = 22'(PLC_CYCLES);

  // settings
  logic [15:0] in_delay_q [dio_map_pkg::NUM_DELAYED]; // tenths
  logic [dio_map_pkg::NUM_DI-1:0] in_pol_q; // 1 = low level active
  logic [5:0] in_func_q [dio_map_pkg::NUM_DI]; // input functions
  logic timing_en_q; // timing function enable
  logic norev_set_q; // reverse prohibit setting
  logic [1:0] scheme_q; // configured run command scheme
  logic mux_mode_q; // 0 pulse, 1 open collector
  logic [5:0] out_func_q [dio_map_pkg::NUM_DO]; // output selectors
  logic [15:0] pulse_per_q; // pulse period in cycles, 0 = idle
  logic [15:0] rdata_q; // read data

  // input side state
  logic [21:0] tick_cnt_q; // 0.1 s prescaler
  logic tick_q; // tick pulse
  logic [dio_map_pkg::NUM_DI-1:0] pin_lvl; // accepted levels
  logic [dio_map_pkg::NUM_DI-1:0] active; // after polarity
  logic [dio_map_pkg::NUM_DI-1:0] active_q; // previous active
  logic [dio_map_pkg::NUM_DI-1:0] is_clr, is_wire, is_norev;
  logic clr_rise, wire_act, norev_act;
  logic clr_q, norev_q;
  logic [1:0] scheme_out_q;

  // output side state
  logic [21:0] plc_cnt_q; // pulse width counter
  logic [41:0] cond; // condition per output function
  logic [dio_map_pkg::NUM_DO-1:0] term_d, term_q;
  logic mux_q;
  logic [15:0] half_cnt_q, half_tgt;
  logic pulse_q, pulse_idle;

  // selects one function condition, undefined codes give off
  function automatic logic pick(input logic [5:0] sel, input logic [41:0] c);
    if (sel > 6'(dio_map_pkg::FUNC_MAX)) begin
      pick = 1'b0;
    end else begin
      pick = c[sel];
    end
  endfunction : pick

  // clamps a delay setting to its range
  function automatic logic [15:0] clamp_delay(input logic [15:0] v);
    clamp_delay = (v > dio_map_pkg::DELAY_MAX) ? dio_map_pkg::DELAY_MAX : v;
  endfunction : clamp_delay

  // register write decode
  wire wr_ctrl = wr && (addr == dio_map_pkg::REG_CTRL);
  wire wr_pol = wr && (addr == dio_map_pkg::REG_IN_POL);
  wire wr_per = wr && (addr == dio_map_pkg::REG_PULSE_PER);

  // register writes, each setting has a reset value
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_pol_q <= '0;
      timing_en_q <= 1'b0;
      norev_set_q <= 1'b0;
      scheme_q <= dio_map_pkg::SCHEME_TWO_WIRE1;
      mux_mode_q <= 1'b0;
      pulse_per_q <= 16'h0000;
    end else begin
      if (wr_pol) begin
        in_pol_q <= wdata[dio_map_pkg::NUM_DI-1:0];
      end
      if (wr_ctrl) begin
        timing_en_q <= wdata[dio_map_pkg::CTRL_TIMING_BIT];
        norev_set_q <= wdata[dio_map_pkg::CTRL_NOREV_BIT];
        scheme_q <= wdata[dio_map_pkg::CTRL_SCHEME_LSB+:2];
        mux_mode_q <= wdata[dio_map_pkg::CTRL_MUXMODE_BIT];
      end
      if (wr_per) begin
        pulse_per_q <= wdata;
      end
    end
  end

  // delay, input function and output selector arrays
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < dio_map_pkg::NUM_DELAYED; i++) begin
        in_delay_q[i] <= 16'h0000;
      end
      for (int i = 0; i < dio_map_pkg::NUM_DI; i++) begin
        in_func_q[i] <= 6'h00;
      end
      for (int i = 0; i < dio_map_pkg::NUM_DO; i++) begin
        out_func_q[i] <= dio_map_pkg::OUT_FUNC_RST[i];
      end
    end else if (wr) begin
      for (int i = 0; i < dio_map_pkg::NUM_DELAYED; i++) begin
        if (addr == dio_map_pkg::REG_IN_DELAY0 + 6'(i)) begin
          in_delay_q[i] <= clamp_delay(wdata);
        end
      end
      for (int i = 0; i < dio_map_pkg::NUM_DI; i++) begin
        if (addr == dio_map_pkg::REG_IN_FUNC0 + 6'(i)) begin
          in_func_q[i] <= wdata[5:0];
        end
      end
      for (int i = 0; i < dio_map_pkg::NUM_DO; i++) begin
        if (addr == dio_map_pkg::REG_OUT_FUNC0 + 6'(i)) begin
          out_func_q[i] <= wdata[5:0];
        end
      end
    end
  end

  // read mux, unmapped addresses read zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < dio_map_pkg::NUM_DELAYED; i++) begin
      if (addr == dio_map_pkg::REG_IN_DELAY0 + 6'(i)) rd_mux = in_delay_q[i];
    end
    for (int i = 0; i < dio_map_pkg::NUM_DI; i++) begin
      if (addr == dio_map_pkg::REG_IN_FUNC0 + 6'(i)) rd_mux = {10'h000, in_func_q[i]};
    end
    for (int i = 0; i < dio_map_pkg::NUM_DO; i++) begin
      if (addr == dio_map_pkg::REG_OUT_FUNC0 + 6'(i)) rd_mux = {10'h000, out_func_q[i]};
    end
    if (addr == dio_map_pkg::REG_IN_POL) rd_mux = {11'h000, in_pol_q};
    if (addr == dio_map_pkg::REG_CTRL) begin
      rd_mux = {11'h000, mux_mode_q, scheme_q, norev_set_q, timing_en_q};
    end
    if (addr == dio_map_pkg::REG_PULSE_PER) rd_mux = pulse_per_q;
    if (addr == dio_map_pkg::REG_STATUS) rd_mux = {3'h0, term_q, 3'h0, active};
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd ? rd_mux : 16'h0000;
    end
  end
  assign rdata = rdata_q;

  // 0.1 s tick for the delay counters
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_cnt_q <= 22'h000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 22'h000000 : tick_cnt_q + 22'h000001;
    end
  end

  // per-terminal filters, only the first three carry a delay
  logic [dio_map_pkg::NUM_DI-1:0] pins;
  assign pins = {dig_in_five, dig_in_four, dig_in_three, dig_in_two, dig_in_one};
  for (genvar g = 0; g < dio_map_pkg::NUM_DI; g++) begin : g_in
    wire [15:0] dly = (g < dio_map_pkg::NUM_DELAYED) ?
                      in_delay_q[g % dio_map_pkg::NUM_DELAYED] : 16'h0000; // index kept in range
    di_delay_filter u_flt (
      .clk(clk),
      .nrst(nrst),
      .pin(pins[g]),
      .tick(tick_q),
      .delay(dly),
      .level(pin_lvl[g])
    );
    assign active[g] = pin_lvl[g] ^ in_pol_q[g];
    assign is_clr[g] = (in_func_q[g] == dio_map_pkg::IN_FUNC_CLR_TIME);
    assign is_wire[g] = (in_func_q[g] == dio_map_pkg::IN_FUNC_WIRE_SW);
    assign is_norev[g] = (in_func_q[g] == dio_map_pkg::IN_FUNC_NO_REV);
  end

  // input function decode
  assign clr_rise = |(is_clr & active & ~active_q) & timing_en_q;
  assign wire_act = |(is_wire & active);
  assign norev_act = |(is_norev & active) | norev_set_q;

  // input function results, registered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      active_q <= '0;
      clr_q <= 1'b0;
      norev_q <= 1'b0;
      scheme_out_q <= dio_map_pkg::SCHEME_TWO_WIRE1;
    end else begin
      active_q <= active;
      clr_q <= clr_rise;
      norev_q <= norev_act;
      if (wire_act && scheme_q == dio_map_pkg::SCHEME_TWO_WIRE1) begin
        scheme_out_q <= dio_map_pkg::SCHEME_THREE_WIRE1;
      end else begin
        scheme_out_q <= scheme_q;
      end
    end
  end
  assign run_time_clear = clr_q;
  assign reverse_prohibit = norev_q;
  assign eff_run_scheme = scheme_out_q;

  // cycle-complete pulse stretcher, retriggers on a new event
  always_ff @(posedge clk) begin
    if (!nrst) begin
      plc_cnt_q <= 22'h000000;
    end else if (plc_cycle_done) begin
      plc_cnt_q <= PLC_LOAD;
    end else if (plc_cnt_q != 22'h000000) begin
      plc_cnt_q <= plc_cnt_q - 22'h000001;
    end
  end

  // condition vector, index is the output function code
  always_comb begin
    cond = '0; // codes 0, 14 and 20 up stay off
    cond[1] = running;
    cond[2] = fault_stop;
    cond[3] = freq_level_det;
    cond[4] = freq_reached;
    cond[5] = running & zero_freq;
    cond[6] = motor_ovl_pending;
    cond[7] = drive_ovl_pending;
    cond[8] = set_count_hit;
    cond[9] = desig_count_hit;
    cond[10] = length_over;
    cond[11] = (plc_cnt_q != 22'h000000);
    cond[12] = accum_run_over;
    cond[13] = freq_limited;
    cond[15] = drive_ready;
    cond[16] = analog_in_first > analog_in_second;
    cond[17] = freq_upper_hit;
    cond[18] = freq_lower_hit & running;
    cond[19] = undervoltage;
  end

  for (genvar g = 0; g < dio_map_pkg::NUM_DO; g++) begin : g_out
    assign term_d[g] = pick(out_func_q[g], cond);
  end

  // pulse generator, half period never below the 100 kHz limit
  assign pulse_idle = (pulse_per_q == 16'h0000) | mux_mode_q;
  assign half_tgt = ((pulse_per_q >> 1) < dio_map_pkg::PULSE_MIN_HALF) ?
                    dio_map_pkg::PULSE_MIN_HALF : (pulse_per_q >> 1);
  always_ff @(posedge clk) begin
    if (!nrst || pulse_idle) begin
      half_cnt_q <= 16'h0001;
      pulse_q <= 1'b0;
    end else if (half_cnt_q >= half_tgt) begin
      half_cnt_q <= 16'h0001;
      pulse_q <= ~pulse_q;
    end else begin
      half_cnt_q <= half_cnt_q + 16'h0001;
    end
  end

  // terminal registers, refreshed every cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      term_q <= '0;
      mux_q <= 1'b0;
    end else begin
      term_q <= term_d;
      mux_q <= mux_mode_q ? term_d[0] : pulse_q;
    end
  end
  assign multiplexed_output = mux_q;
  assign main_relay_out = term_q[1];
  assign ext_relay_out = term_q[2];
  assign first_digital_output = term_q[3];
  assign second_digital_output = term_q[4];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  localparam int HALF_MIN_I = dio_map_pkg::PULSE_MIN_PERIOD / 2;
  logic [15:0] gap_q; // cycles since last pulse edge
  always_ff @(posedge clk) begin
    if (!nrst || mux_mode_q) gap_q <= 16'h0000;
    else if (mux_q != $past(mux_q)) gap_q <= 16'h0001;
    else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
  end

  chk_pulse_rate_limit: assert property (
    !mux_mode_q && $past(!mux_mode_q) && gap_q != 16'h0000 && $changed(mux_q)
    |-> gap_q >= 16'(HALF_MIN_I)) else $error("pulse edges too close");
  chk_oc_mode_follow: assert property (
    mux_mode_q |=> multiplexed_output == $past(term_d[0]))
    else $error("open collector output wrong");
  chk_undef_sel_off: assert property (
    out_func_q[3] == 6'h00 || out_func_q[3] == 6'h0E || out_func_q[3] > 6'h13
    |=> !first_digital_output) else $error("undefined function drives output");
  chk_running_follow: assert property (
    out_func_q[3] == 6'h01 |=> first_digital_output == $past(running))
    else $error("running output wrong");
  chk_zero_speed_stop: assert property (
    out_func_q[3] == 6'h05 && !running |=> !first_digital_output)
    else $error("zero speed on while stopped");
  chk_lower_limit_stop: assert property (
    out_func_q[3] == 6'h12 && !running |=> !first_digital_output)
    else $error("lower limit on while stopped");
  chk_plc_pulse_hold: assert property (
    plc_cycle_done && out_func_q[3] == 6'h0B ##1 out_func_q[3] == 6'h0B [*8]
    |-> first_digital_output [*8]) else $error("cycle pulse too short");
  chk_clear_gated: assert property (
    run_time_clear |-> $past(timing_en_q)) else $error("clear without timing enable");
  chk_wire_switch: assert property (
    wire_act && scheme_q == dio_map_pkg::SCHEME_TWO_WIRE1
    |=> eff_run_scheme == dio_map_pkg::SCHEME_THREE_WIRE1) else $error("scheme not switched");
  chk_reverse_block: assert property (
    norev_set_q |=> reverse_prohibit) else $error("reverse not prohibited");
  chk_ai_compare: assert property (
    out_func_q[3] == 6'h10 |=> first_digital_output == $past(analog_in_first > analog_in_second))
    else $error("analog compare wrong");

  cov_clear_event: cover property (run_time_clear);
  cov_pulse_toggle: cover property (!mux_mode_q ##1 $changed(mux_q));
  cov_plc_pulse: cover property (plc_cycle_done ##1 cond[11] [*4]);
  cov_scheme_switch: cover property (eff_run_scheme == dio_map_pkg::SCHEME_THREE_WIRE1);
endmodule : drive_terminal_io_mapper
